// file: asbp_consts.svh
// Constants for the asynchronous SRAM byte port host controller
// What this block does
// - Address valid by select falling.
// - Host never drives during reads.
// - Wait 1 us after power-up.
// - Write address stable at write start.
// - Address held 10 ns before write end.
// - Data valid 7 ns before write end.
// - Address unchanged until write ended.
`ifndef ASBP_CONSTS_SVH
`define ASBP_CONSTS_SVH
`define ASBP_ADDR_W          19
`define ASBP_DATA_W          8
`define ASBP_CLK_PS          25000
`define ASBP_POWERUP_NS      1000
`define ASBP_ADDR_ACCESS_NS  12
`define ASBP_OE_ACCESS_NS    6
`define ASBP_WR_ADDR_SU_NS   10
`define ASBP_WR_DATA_SU_NS   7
`define ASBP_POWERUP_CYC     ((`ASBP_POWERUP_NS * 1000 + `ASBP_CLK_PS - 1) / `ASBP_CLK_PS)
`define ASBP_READ_CYC        ((`ASBP_ADDR_ACCESS_NS * 1000 + `ASBP_CLK_PS - 1) / `ASBP_CLK_PS)
`define ASBP_WRITE_CYC       ((`ASBP_WR_ADDR_SU_NS * 1000 + `ASBP_CLK_PS - 1) / `ASBP_CLK_PS)
`define ASBP_CNT_W           6
`endif

// file: asbp_pkg.sv
// Types for the asynchronous SRAM byte port host controller
package asbp_pkg;
    typedef logic [18:0] asbp_addr_t;
    typedef logic [7:0]  asbp_data_t;
    typedef enum logic [5:0] {
        ASBP_POWERUP = 6'b000001,
        ASBP_IDLE    = 6'b000010,
        ASBP_RD      = 6'b000100,
        ASBP_RD_DONE = 6'b001000,
        ASBP_WR      = 6'b010000,
        ASBP_WR_END  = 6'b100000
    } asbp_state_t;
endpackage

// file: asbp_wait_timer.sv
// Down counter that times the controller phases
`timescale 1ns/1ps
`include "asbp_consts.svh"
module asbp_wait_timer (
    // Clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_n_in,
    // Control
    input  wire logic                   load_in,
    input  wire logic [`ASBP_CNT_W-1:0] value_in,
    // Status
    output logic                        done_out
);
    typedef struct packed {
        logic [`ASBP_CNT_W-1:0] count;
    } asbp_tmr_t;
    asbp_tmr_t st;
    asbp_tmr_t next_st;

    always_comb begin
        next_st = st;
        if (load_in) begin
            next_st.count = value_in;
        end else if (st.count != '0) begin
            next_st.count = st.count - 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign done_out = (st.count == '0) && !load_in;
endmodule

// file: asbp_host.sv
// Host controller driving an asynchronous 512K x 8 SRAM
`timescale 1ns/1ps
`include "asbp_consts.svh"
module asbp_host (
    // Clock and reset
    input  wire logic                core_clk_in,
    input  wire logic                rst_n_in,
    // User request
    input  wire logic                req_valid_in,
    input  wire logic                req_write_in,
    input  wire asbp_pkg::asbp_addr_t req_addr_in,
    input  wire asbp_pkg::asbp_data_t req_wdata_in,
    output logic                     req_ready_out,
    // User answer
    output logic                     rsp_valid_out,
    output asbp_pkg::asbp_data_t     rsp_rdata_out,
    output logic                     powerup_done_out,
    // Memory pins
    output asbp_pkg::asbp_addr_t     address_lines_out,
    output logic                     select_n_out,
    output logic                     out_enable_n_out,
    output logic                     write_enable_n_out,
    input  wire asbp_pkg::asbp_data_t data_bus_in,
    output asbp_pkg::asbp_data_t     data_bus_out,
    output logic                     data_bus_oe_out
);
    import asbp_pkg::*;

    localparam logic [`ASBP_CNT_W-1:0] POWERUP_CNT = (`ASBP_CNT_W)'(`ASBP_POWERUP_CYC - 1);
    localparam logic [`ASBP_CNT_W-1:0] READ_CNT    = (`ASBP_CNT_W)'(`ASBP_READ_CYC - 1);
    localparam logic [`ASBP_CNT_W-1:0] WRITE_CNT   = (`ASBP_CNT_W)'(`ASBP_WRITE_CYC - 1);

    typedef struct packed {
        asbp_state_t state;
        asbp_addr_t  addr;
        asbp_data_t  wdata;
        asbp_data_t  rdata;
        logic        rsp;
        logic        sel_n;
        logic        oe_n;
        logic        we_n;
        logic        drive;
        logic        pwr_ok;
        logic        kick;
    } asbp_host_st_t;

    asbp_host_st_t st;
    asbp_host_st_t next_st;
    logic                   tmr_load;
    logic [`ASBP_CNT_W-1:0] tmr_value;
    logic                   tmr_done;

    asbp_wait_timer u_timer (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .load_in     (tmr_load),
        .value_in    (tmr_value),
        .done_out    (tmr_done)
    );

    always_comb begin
        next_st     = st;
        next_st.rsp = 1'b0;
        next_st.kick = 1'b0;
        tmr_load    = 1'b0;
        tmr_value   = READ_CNT;
        unique case (st.state)
            ASBP_POWERUP: begin
                if (st.kick) begin
                    // Timer count is zero after reset, so arm the full wait first
                    tmr_load  = 1'b1;
                    tmr_value = POWERUP_CNT;
                end else if (tmr_done) begin
                    next_st.pwr_ok = 1'b1;
                    next_st.state  = ASBP_IDLE;
                end
            end
            ASBP_IDLE: begin
                if (req_valid_in) begin
                    next_st.addr  = req_addr_in;
                    next_st.sel_n = 1'b0;
                    tmr_load      = 1'b1;
                    if (req_write_in) begin
                        next_st.wdata = req_wdata_in;
                        next_st.we_n  = 1'b0;
                        next_st.drive = 1'b1;
                        tmr_value     = WRITE_CNT;
                        next_st.state = ASBP_WR;
                    end else begin
                        next_st.oe_n  = 1'b0;
                        next_st.drive = 1'b0;
                        next_st.state = ASBP_RD;
                    end
                end
            end
            ASBP_RD: begin
                if (tmr_done) begin
                    next_st.state = ASBP_RD_DONE;
                end
            end
            ASBP_RD_DONE: begin
                // Sample one cycle late so the 12 ns access is always met
                next_st.rdata = data_bus_in;
                next_st.rsp   = 1'b1;
                next_st.oe_n  = 1'b1;
                next_st.sel_n = 1'b1;
                next_st.state = ASBP_IDLE;
            end
            ASBP_WR: begin
                if (tmr_done) begin
                    next_st.we_n  = 1'b1;
                    next_st.state = ASBP_WR_END;
                end
            end
            ASBP_WR_END: begin
                next_st.sel_n = 1'b1;
                next_st.drive = 1'b0;
                next_st.rsp   = 1'b1;
                next_st.state = ASBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            st.state  <= ASBP_POWERUP;
            st.addr   <= '0;
            st.wdata  <= '0;
            st.rdata  <= '0;
            st.rsp    <= 1'b0;
            st.sel_n  <= 1'b1;
            st.oe_n   <= 1'b1;
            st.we_n   <= 1'b1;
            st.drive  <= 1'b0;
            st.pwr_ok <= 1'b0;
            st.kick   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign req_ready_out      = (st.state == ASBP_IDLE);
    assign rsp_valid_out      = st.rsp;
    assign rsp_rdata_out      = st.rdata;
    assign powerup_done_out   = st.pwr_ok;
    assign address_lines_out  = st.addr;
    assign select_n_out       = st.sel_n;
    assign out_enable_n_out   = st.oe_n;
    assign write_enable_n_out = st.we_n;
    assign data_bus_out       = st.wdata;
    assign data_bus_oe_out    = st.drive;
endmodule

// file: asbp_host_assertions.sv
// Checker for the host pin sequencing
`timescale 1ns/1ps
module asbp_host_chk (
    input wire logic         core_clk_in,
    input wire logic         rst_n_in,
    input wire logic         req_valid_in,
    input wire logic         req_write_in,
    input wire logic         req_ready_out,
    input wire logic         rsp_valid_out,
    input wire logic         powerup_done_out,
    input wire logic [18:0]  address_lines_out,
    input wire logic         select_n_out,
    input wire logic         out_enable_n_out,
    input wire logic         write_enable_n_out,
    input wire logic [7:0]   data_bus_out,
    input wire logic         data_bus_oe_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_no_early_access: assert property (
        !powerup_done_out |-> select_n_out && !req_ready_out) else $error("early access");
    a_read_bus_quiet: assert property (
        !out_enable_n_out |-> !data_bus_oe_out && write_enable_n_out) else $error("bus fight");
    a_sel_addr_hold: assert property (
        !select_n_out && $past(!select_n_out) |-> $stable(address_lines_out))
        else $error("address moved in access");
    a_wr_addr_setup: assert property (
        $rose(write_enable_n_out) |-> $past(!select_n_out)
        && $stable(address_lines_out)) else $error("write address setup");
    a_wr_data_setup: assert property (
        $rose(write_enable_n_out) |-> $past(data_bus_oe_out) && data_bus_oe_out
        && $stable(data_bus_out)) else $error("write data setup");
    a_wr_we_first: assert property (
        $rose(write_enable_n_out) |-> !select_n_out ##1 select_n_out)
        else $error("write end order");
    a_rd_walk: assert property (
        req_valid_in && req_ready_out && !req_write_in |=> !select_n_out
        && !out_enable_n_out ##[2:3] rsp_valid_out) else $error("read sequence");
    a_wr_walk: assert property (
        req_valid_in && req_ready_out && req_write_in |=> !write_enable_n_out
        && data_bus_oe_out ##2 rsp_valid_out) else $error("write sequence");
endmodule
bind asbp_host asbp_host_chk u_chk (.core_clk_in, .rst_n_in, .req_valid_in, .req_write_in,
    .req_ready_out, .rsp_valid_out, .powerup_done_out, .address_lines_out, .select_n_out,
    .out_enable_n_out, .write_enable_n_out, .data_bus_out, .data_bus_oe_out);

// file: asbp_sram_model.sv
// Behavioural byte memory on the far side of the host
`timescale 1ns/1ps
// Select delay plus the 3 ns address hold lands on the 12 ns access time
module asbp_sram_model #(parameter int DLY = 9) (
    input  wire logic [18:0] addr_in,
    input  wire logic        sel_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic [7:0]  host_data_in,
    input  wire logic        host_oe_in,
    output logic [7:0]       bus_out
);
    logic [7:0]  mem [logic [18:0]];
    logic [7:0]  wd, rd, last;
    logic [18:0] wa;
    logic        drv, wr_on;
    // follow the bus while writing, store at first rising control
    assign wr_on = !sel_n_in && !we_n_in;
    always @* if (wr_on) {wa, wd} = {addr_in, bus_out};
    always @(negedge wr_on) mem[wa] = wd;
    // drive only a clean read, stop soon after deselect
    assign #(DLY) drv = !sel_n_in && !oe_n_in && we_n_in;
    // old byte lingers after the address moves
    always @(addr_in, drv) rd <= #3 (mem.exists(addr_in) ? mem[addr_in] : 8'h00);
    // Released bus shows the inverse, so a late sample cannot pass by luck
    always @* if (host_oe_in || drv) last = host_oe_in ? host_data_in : rd;
    assign bus_out = host_oe_in ? host_data_in : drv ? rd : ~last;
endmodule

// file: tb_top.sv
// Self-checking bench for the host controller
`timescale 1ns/1ps
module tb_top;
    import asbp_pkg::*;
    logic       core_clk_in = 0, rst_n_in = 0, req_valid_in = 0, req_write_in = 0;
    asbp_addr_t req_addr_in = '0, address_lines_out;
    asbp_data_t req_wdata_in = '0, rsp_rdata_out, data_bus_in, data_bus_out;
    logic       req_ready_out, rsp_valid_out, powerup_done_out, select_n_out;
    logic       out_enable_n_out, write_enable_n_out, data_bus_oe_out;
    int         error_cnt = 0, checks = 0, n;
    integer     seed = 205;
    logic [7:0] ref_mem [logic [18:0]];
    asbp_host dut (.core_clk_in, .rst_n_in, .req_valid_in, .req_write_in, .req_addr_in,
        .req_wdata_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .powerup_done_out,
        .address_lines_out, .select_n_out, .out_enable_n_out, .write_enable_n_out,
        .data_bus_in, .data_bus_out, .data_bus_oe_out);
    asbp_sram_model mdl (.addr_in(address_lines_out), .sel_n_in(select_n_out),
        .oe_n_in(out_enable_n_out), .we_n_in(write_enable_n_out),
        .host_data_in(data_bus_out), .host_oe_in(data_bus_oe_out), .bus_out(data_bus_in));
    initial forever #12.5 core_clk_in = ~core_clk_in;
    function automatic asbp_data_t exp_rd(asbp_addr_t a);
        return ref_mem.exists(a) ? ref_mem[a] : 8'h00;
    endfunction
    task automatic check(string what, logic [18:0] exp, logic [18:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test;
        if (error_cnt == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Requests go out at the falling edge, the next is offered as the answer lands
    task automatic op(logic w, asbp_addr_t a, asbp_data_t d);
        n = 0;
        {req_valid_in, req_write_in, req_addr_in, req_wdata_in} = {1'b1, w, a, d};
        while (req_ready_out !== 1'b1 && n < 99) begin
            @(negedge core_clk_in);
            n++;
        end
        @(negedge core_clk_in);
        req_valid_in = 0;
        while (rsp_valid_out !== 1'b1 && n < 99) begin
            @(negedge core_clk_in);
            n++;
        end
        check("handshake timeout", 0, n >= 99);
        if (w) ref_mem[a] = d;
        else check("read data", exp_rd(a), rsp_rdata_out);
    endtask
    initial begin
        repeat (20) @(negedge core_clk_in);
        rst_n_in = 1;
        // A write offered during the power-up wait must be left untaken
        {req_valid_in, req_write_in, req_addr_in, req_wdata_in} = {2'b11, 19'h5, 8'h5a};
        repeat (30) @(negedge core_clk_in);
        check("early ready", 0, req_ready_out);
        req_valid_in = 0;
        n = 30;
        while (powerup_done_out !== 1'b1 && n < 99) begin
            @(negedge core_clk_in);
            n++;
        end
        check("powerup in range", 1, n >= 40 && n <= 42);
        op(0, 19'h5, 8'h0);
        op(1, 19'h0, 8'hff);
        op(1, 19'h7ffff, 8'ha5);
        op(0, 19'h7ffff, 8'h0);
        op(0, 19'h0, 8'h0);
        repeat (200) op(1'($random(seed)), 19'($random(seed)) & 19'h7000f, 8'($random(seed)));
        finish_test;
    end
    initial begin
        #200000;
        error_cnt++;
        finish_test;
    end
endmodule
